// file: ccss_pkg.sv
`default_nettype none
package ccss_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_RUN  = 8'h04;
	localparam logic [7:0] OFS_SEL  = 8'h08;
	localparam logic [7:0] OFS_LSP  = 8'h0C;
	localparam logic [7:0] OFS_SUBM = 8'h10;
	localparam logic [7:0] OFS_STS  = 8'h14;
	localparam logic [7:0] OFS_STC  = 8'h18;
	localparam logic [7:0] OFS_FDIV = 8'h1C;
	localparam logic [7:0] OFS_MAIN_CLOCK_DIVIDER = 8'h20;
	localparam logic [7:0] OFS_OPT  = 8'h24;

	// Field positions
	localparam int RUN_MAIN_HALT = 7;
	localparam int RUN_SUB_HALT  = 6;
	localparam int RUN_FAST_HALT = 0;
	localparam int SEL_CPU_STAT  = 7;
	localparam int SEL_CPU_SEL   = 6;
	localparam int SEL_MAIN_STAT = 5;
	localparam int SEL_MAIN_SEL  = 4;
	localparam int LSP_LS_SEL    = 0;
	localparam int SUBM_LOWPWR   = 7;
	localparam int OPT_RANGE     = 4;

	// Reset values
	localparam logic       RST_MAIN_HALT = 1'h1;
	localparam logic       RST_SUB_HALT  = 1'h1;
	localparam logic       RST_FAST_HALT = 1'h0;
	localparam logic [2:0] RST_STS       = 3'h7;
	localparam logic [2:0] RST_FDIV      = 3'h0;
	localparam logic [2:0] RST_MAIN_CLOCK_DIVIDER      = 3'h0;
	localparam logic [7:0] RST_MODE      = 8'h00;

	// Oscillator pin modes
	localparam logic [1:0] MODE_PORT = 2'h0;
	localparam logic [1:0] MODE_OSC  = 2'h1;
	localparam logic [1:0] MODE_EXT  = 2'h3;

	// Fast oscillator option frequencies, MHz
	localparam logic [15:0] ACLK_MHZ      = 16'h00C8;
	localparam logic [3:0]  FAST_IDX_LAST = 4'h8;
	localparam logic [6:0]  FAST_FREQ_MHZ [0:8] = '{7'h01, 7'h04, 7'h08, 7'h0C, 7'h10,
		7'h18, 7'h20, 7'h30, 7'h40};

	// Stabilization counter thermometer base (2^8 ticks)
	localparam int STAB_LOG_BASE = 8;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Operation mode register layout
	typedef struct packed {
		logic main_ext;
		logic main_pin;
		logic sub_ext;
		logic sub_pin;
		logic drive_hi;
		logic drive_lo;
		logic unused;
		logic gain_high;
	} ccss_mode_t;

endpackage : ccss_pkg
`default_nettype wire

// file: ccss_switch_cell.sv
`default_nettype none
module ccss_switch_cell
	import ccss_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic sel_req,
	input  wire logic tick_a,
	input  wire logic tick_b,
	input  wire logic live_a,
	input  wire logic live_b,
	output logic      tick_out,
	output logic      sel_cur
);

	typedef enum logic [1:0] {CELL_RUN, CELL_DRAIN, CELL_ARM} ccss_cell_t;

	ccss_cell_t state_ff;
	logic       cur_ff;
	logic       stat_ff;
	logic       old_tick;
	logic       old_live;
	logic       new_tick;

	// Source in use; changes at an old-source edge, or at once if the old source is stopped
	assign tick_out = cur_ff ? tick_b : tick_a;
	assign sel_cur  = stat_ff;
	assign old_tick = cur_ff ? tick_b : tick_a;
	assign old_live = cur_ff ? live_b : live_a;
	assign new_tick = cur_ff ? tick_b : tick_a;

	// Changeover sequence
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= CELL_RUN;
			cur_ff   <= 1'h0;
			stat_ff  <= 1'h0;
		end else begin
			case (state_ff)
				CELL_RUN: begin
					if (sel_req != cur_ff) state_ff <= CELL_DRAIN;
				end
				CELL_DRAIN: begin
					if (sel_req == cur_ff) begin
						state_ff <= CELL_RUN;
					end else if (old_tick || !old_live) begin
						cur_ff   <= sel_req;
						state_ff <= CELL_ARM;
					end
				end
				CELL_ARM: begin
					if (new_tick) begin
						stat_ff  <= cur_ff;
						state_ff <= CELL_RUN;
					end
				end
				default: state_ff <= CELL_RUN;
			endcase
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	stat_on_tick_a: assert property ($changed(stat_ff) |-> $past(tick_out))
		else $error("status changed without a new-source edge");
	stat_tracks_a: assert property ($changed(stat_ff) |-> stat_ff == cur_ff)
		else $error("status disagrees with multiplexer");

endmodule : ccss_switch_cell
`default_nettype wire

// file: ccss_top.sv
`default_nettype none
module ccss_top
	import ccss_pkg::*;
#(
	parameter int ADDR_W        = 8,
	parameter int LOW_SPEED_DIV = 13333
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [3:0]        option_freq_sel,
	input  wire logic              fast_osc_range_option,
	input  wire logic [1:0]        main_crystal_osc,
	input  wire logic              sub_crystal_osc,
	output logic [1:0]             main_pins_port_data,
	output logic                   main_osc_enable,
	output logic                   main_osc_gain_high,
	output logic                   sub_osc_enable,
	output logic [1:0]             sub_osc_drive,
	output logic                   sub_low_power_ctrl,
	output logic                   fast_internal_clk_en,
	output logic                   main_system_clk_en,
	output logic                   cpu_peripheral_clock
);

	// Bus slave state
	logic [7:0]  awaddr_ff;
	logic        aw_have_ff;
	logic [7:0]  wdata_ff;
	logic        wen_ff;
	logic        w_have_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [1:0]  rresp_ff;
	logic [31:0] rdata_ff;
	logic        wr_go;
	logic        wr_mapped;
	logic        wr_en;
	logic [7:0]  rd_addr;
	logic [31:0] nxt_rdata;
	logic        rd_mapped;

	// Control registers
	ccss_mode_t  mode_ff;
	logic        mode_locked_ff;
	logic        main_halt_ff;
	logic        sub_halt_ff;
	logic        fast_halt_ff;
	logic        main_sel_ff;
	logic        cpu_sel_ff;
	logic        ls_sel_ff;
	logic        sub_lp_ff;
	logic [2:0]  sts_ff;
	logic [2:0]  fdiv_ff;
	logic [2:0]  main_clock_divider_ff;

	// Option capture, pin synchronisers, clock sources
	logic [4:0]  opt_s1_ff;
	logic [4:0]  opt_s2_ff;
	logic [1:0]  opt_cnt_ff;
	logic        opt_done_ff;
	logic [3:0]  opt_idx_ff;
	logic        opt_range_ff;
	logic [1:0]  main_s1_ff;
	logic [1:0]  main_s2_ff;
	logic        main_d_ff;
	logic        sub_s1_ff;
	logic        sub_s2_ff;
	logic        sub_d_ff;
	logic [15:0] fast_acc_ff;
	logic        fast_tick_ff;
	logic [15:0] fast_sum;
	logic [15:0] fast_lim;
	logic [6:0]  fast_inc;
	logic        fast_live;
	logic [1:0]  main_mode;
	logic [1:0]  sub_mode;
	logic        main_xtal_live;
	logic        main_xtal_tick;
	logic [15:0] stab_cnt_ff;
	logic [7:0]  stab_therm;
	logic        main_ready;
	logic [6:0]  main_clock_divider_cnt_ff;
	logic        main_div_tick_ff;
	logic        sub_live;
	logic        sub_tick_ff;
	logic [15:0] ls_cnt_ff;
	logic        ls_tick_ff;
	logic [1:0]  port_data_ff;
	logic        main_sys_tick;
	logic        main_stat;
	logic        main_sys_live;
	logic        sub_path_tick;
	logic        ls_stat;
	logic        sub_path_live;
	logic        cpu_stat;

	// Write and read channel acceptance
	assign s_axi_awready = !aw_have_ff && !bvalid_ff;
	assign s_axi_wready  = !w_have_ff && !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = rdata_ff;
	assign wr_go = aw_have_ff && w_have_ff && !bvalid_ff;
	assign wr_mapped = (awaddr_ff <= OFS_OPT) && (awaddr_ff[1:0] == 2'h0);
	assign wr_en = wr_go && wen_ff;

	// Address and data latch, then write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_ff  <= 8'h00;
			aw_have_ff <= 1'h0;
			wdata_ff   <= 8'h00;
			wen_ff     <= 1'h0;
			w_have_ff  <= 1'h0;
			bvalid_ff  <= 1'h0;
			bresp_ff   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_ff  <= 8'(s_axi_awaddr);
				aw_have_ff <= 1'h1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_ff  <= s_axi_wdata[7:0];
				wen_ff    <= s_axi_wstrb[0];
				w_have_ff <= 1'h1;
			end
			if (wr_go) begin
				aw_have_ff <= 1'h0;
				w_have_ff  <= 1'h0;
				bvalid_ff  <= 1'h1;
				bresp_ff   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'h0;
			end
		end
	end

	// Operation mode register, locked after its first write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_ff        <= RST_MODE;
			mode_locked_ff <= 1'h0;
		end else if (wr_en && awaddr_ff == OFS_MODE && !mode_locked_ff) begin
			mode_ff        <= wdata_ff;
			mode_locked_ff <= 1'h1;
		end
	end

	// Run control and clock select registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			main_halt_ff <= RST_MAIN_HALT;
			sub_halt_ff  <= RST_SUB_HALT;
			fast_halt_ff <= RST_FAST_HALT;
			main_sel_ff  <= 1'h0;
			cpu_sel_ff   <= 1'h0;
			ls_sel_ff    <= 1'h0;
			sub_lp_ff    <= 1'h0;
			sts_ff       <= RST_STS;
			fdiv_ff      <= RST_FDIV;
			main_clock_divider_ff      <= RST_MAIN_CLOCK_DIVIDER;
		end else if (wr_en) begin
			case (awaddr_ff)
				OFS_RUN: begin
					main_halt_ff <= wdata_ff[RUN_MAIN_HALT];
					sub_halt_ff  <= wdata_ff[RUN_SUB_HALT];
					fast_halt_ff <= wdata_ff[RUN_FAST_HALT];
				end
				OFS_SEL: begin
					main_sel_ff <= wdata_ff[SEL_MAIN_SEL];
					cpu_sel_ff  <= wdata_ff[SEL_CPU_SEL];
				end
				OFS_LSP:  ls_sel_ff <= wdata_ff[LSP_LS_SEL];
				OFS_SUBM: sub_lp_ff <= wdata_ff[SUBM_LOWPWR];
				OFS_STS:  sts_ff    <= wdata_ff[2:0];
				OFS_FDIV: fdiv_ff   <= wdata_ff[2:0];
				OFS_MAIN_CLOCK_DIVIDER: main_clock_divider_ff   <= wdata_ff[2:0];
				default: ;
			endcase
		end
	end

	// Read data mux
	assign rd_addr = 8'(s_axi_araddr);
	assign rd_mapped = (rd_addr <= OFS_OPT) && (rd_addr[1:0] == 2'h0);
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		case (rd_addr)
			OFS_MODE: nxt_rdata[7:0] = mode_ff;
			OFS_RUN: begin
				nxt_rdata[RUN_MAIN_HALT] = main_halt_ff;
				nxt_rdata[RUN_SUB_HALT]  = sub_halt_ff;
				nxt_rdata[RUN_FAST_HALT] = fast_halt_ff;
			end
			OFS_SEL: begin
				nxt_rdata[SEL_CPU_STAT]  = cpu_stat;
				nxt_rdata[SEL_CPU_SEL]   = cpu_sel_ff;
				nxt_rdata[SEL_MAIN_STAT] = main_stat;
				nxt_rdata[SEL_MAIN_SEL]  = main_sel_ff;
			end
			OFS_LSP:  nxt_rdata[LSP_LS_SEL]  = ls_sel_ff;
			OFS_SUBM: nxt_rdata[SUBM_LOWPWR] = sub_lp_ff;
			OFS_STS:  nxt_rdata[2:0] = sts_ff;
			OFS_STC:  nxt_rdata[7:0] = stab_therm;
			OFS_FDIV: nxt_rdata[2:0] = fdiv_ff;
			OFS_MAIN_CLOCK_DIVIDER: nxt_rdata[2:0] = main_clock_divider_ff;
			OFS_OPT: begin
				nxt_rdata[3:0]       = opt_idx_ff;
				nxt_rdata[OPT_RANGE] = opt_range_ff;
			end
			default: ;
		endcase
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'h0;
			rresp_ff  <= RESP_OKAY;
			rdata_ff  <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'h1;
			rresp_ff  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			rdata_ff  <= nxt_rdata;
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'h0;
		end
	end

	// Option strap: synchronise, then capture once after release
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			opt_s1_ff    <= 5'h00;
			opt_s2_ff    <= 5'h00;
			opt_cnt_ff   <= 2'h0;
			opt_done_ff  <= 1'h0;
			opt_idx_ff   <= 4'h0;
			opt_range_ff <= 1'h0;
		end else begin
			opt_s1_ff <= {fast_osc_range_option, option_freq_sel};
			opt_s2_ff <= opt_s1_ff;
			if (!opt_done_ff) begin
				opt_cnt_ff <= opt_cnt_ff + 2'h1;
				if (opt_cnt_ff == 2'h2) begin
					opt_done_ff  <= 1'h1;
					opt_idx_ff   <= (opt_s2_ff[3:0] > FAST_IDX_LAST) ? 4'h0 : opt_s2_ff[3:0];
					opt_range_ff <= opt_s2_ff[4];
				end
			end
		end
	end

	// Fast oscillator: rate accumulator over the 200 MHz clock
	assign fast_live = opt_done_ff && !fast_halt_ff;
	assign fast_inc  = FAST_FREQ_MHZ[opt_idx_ff];
	assign fast_lim  = 16'(ACLK_MHZ << fdiv_ff);
	assign fast_sum  = fast_acc_ff + 16'(fast_inc);
	always_ff @(posedge aclk) begin
		if (!aresetn || !fast_live) begin
			fast_acc_ff  <= 16'h0000;
			fast_tick_ff <= 1'h0;
		end else if (fast_sum >= fast_lim) begin
			fast_acc_ff  <= (fast_sum - fast_lim >= fast_lim) ? 16'h0000 : fast_sum - fast_lim;
			fast_tick_ff <= 1'h1;
		end else begin
			fast_acc_ff  <= fast_sum;
			fast_tick_ff <= 1'h0;
		end
	end

	// Pin synchronisers and edge detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			main_s1_ff <= 2'h0;
			main_s2_ff <= 2'h0;
			main_d_ff  <= 1'h0;
			sub_s1_ff  <= 1'h0;
			sub_s2_ff  <= 1'h0;
			sub_d_ff   <= 1'h0;
		end else begin
			main_s1_ff <= main_crystal_osc;
			main_s2_ff <= main_s1_ff;
			main_d_ff  <= main_s2_ff[0];
			sub_s1_ff  <= sub_crystal_osc;
			sub_s2_ff  <= sub_s1_ff;
			sub_d_ff   <= sub_s2_ff;
		end
	end

	// Main crystal path: mode decode, stabilization count, divider
	assign main_mode      = {mode_ff.main_ext, mode_ff.main_pin};
	assign main_xtal_live = !main_halt_ff && (main_mode == MODE_OSC || main_mode == MODE_EXT);
	assign main_xtal_tick = main_xtal_live && main_s2_ff[0] && !main_d_ff;
	assign main_ready     = (main_mode == MODE_EXT) || stab_therm[sts_ff];
	always_comb begin
		for (int i = 0; i < 8; i++) stab_therm[i] = |(stab_cnt_ff >> (STAB_LOG_BASE + i));
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || !main_xtal_live || main_mode != MODE_OSC) begin
			stab_cnt_ff <= 16'h0000;
		end else if (main_xtal_tick && stab_cnt_ff != 16'hFFFF) begin
			stab_cnt_ff <= stab_cnt_ff + 16'h0001;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			main_clock_divider_cnt_ff      <= 7'h00;
			main_div_tick_ff <= 1'h0;
		end else begin
			main_div_tick_ff <= 1'h0;
			if (main_xtal_tick && main_ready) begin
				if (main_clock_divider_cnt_ff >= 7'((8'h01 << main_clock_divider_ff) - 8'h01)) begin
					main_clock_divider_cnt_ff      <= 7'h00;
					main_div_tick_ff <= 1'h1;
				end else begin
					main_clock_divider_cnt_ff <= main_clock_divider_cnt_ff + 7'h01;
				end
			end
		end
	end

	// Sub crystal and low-speed internal sources; port mode capture
	assign sub_mode = {mode_ff.sub_ext, mode_ff.sub_pin};
	assign sub_live = !sub_halt_ff && (sub_mode == MODE_OSC || sub_mode == MODE_EXT);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sub_tick_ff  <= 1'h0;
			ls_cnt_ff    <= 16'h0000;
			ls_tick_ff   <= 1'h0;
			port_data_ff <= 2'h0;
		end else begin
			sub_tick_ff <= sub_live && sub_s2_ff && !sub_d_ff;
			ls_tick_ff  <= 1'h0;
			if (!ls_sel_ff) begin
				ls_cnt_ff <= 16'h0000;
			end else if (ls_cnt_ff == 16'(LOW_SPEED_DIV - 1)) begin
				ls_cnt_ff  <= 16'h0000;
				ls_tick_ff <= 1'h1;
			end else begin
				ls_cnt_ff <= ls_cnt_ff + 16'h0001;
			end
			port_data_ff <= (main_mode == MODE_PORT) ? main_s2_ff : 2'h0;
		end
	end

	// Glitch-free multiplexers: main, sub path, CPU
	ccss_switch_cell u_main_cell (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.sel_req  (main_sel_ff),
		.tick_a   (fast_tick_ff),
		.tick_b   (main_div_tick_ff),
		.live_a   (fast_live),
		.live_b   (main_xtal_live),
		.tick_out (main_sys_tick),
		.sel_cur  (main_stat)
	);
	ccss_switch_cell u_sub_cell (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.sel_req  (ls_sel_ff),
		.tick_a   (sub_tick_ff),
		.tick_b   (ls_tick_ff),
		.live_a   (sub_live),
		.live_b   (ls_sel_ff),
		.tick_out (sub_path_tick),
		.sel_cur  (ls_stat)
	);
	assign main_sys_live = main_stat ? main_xtal_live : fast_live;
	assign sub_path_live = ls_stat ? ls_sel_ff : sub_live;
	ccss_switch_cell u_cpu_cell (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.sel_req  (cpu_sel_ff),
		.tick_a   (main_sys_tick),
		.tick_b   (sub_path_tick),
		.live_a   (main_sys_live),
		.live_b   (sub_path_live),
		.tick_out (cpu_peripheral_clock),
		.sel_cur  (cpu_stat)
	);

	// Analog and pin controls
	assign main_pins_port_data  = port_data_ff;
	assign main_osc_enable      = main_xtal_live && main_mode == MODE_OSC;
	assign main_osc_gain_high   = mode_ff.gain_high;
	assign sub_osc_enable       = !sub_halt_ff && sub_mode == MODE_OSC;
	assign sub_osc_drive        = {mode_ff.drive_hi, mode_ff.drive_lo};
	assign sub_low_power_ctrl   = sub_lp_ff;
	assign fast_internal_clk_en = fast_tick_ff;
	assign main_system_clk_en   = main_sys_tick;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	reset_source_a: assert property ($rose(aresetn) |-> !main_stat && !cpu_stat && !fast_halt_ff)
		else $error("reset did not select fast oscillator");
	option_hold_a: assert property (opt_done_ff |=> $stable(opt_idx_ff) && opt_done_ff)
		else $error("option index changed after capture");
	fast_divide_a: assert property (fast_tick_ff && fdiv_ff != 3'h0 |=> !fast_tick_ff [*5])
		else $error("divided fast clock too fast");
	fast_restart_a: assert property (wr_en && awaddr_ff == OFS_RUN && !wdata_ff[RUN_FAST_HALT]
		|=> !fast_halt_ff ##3 fast_live)
		else $error("fast oscillator not restarted");
	port_mode_a: assert property (main_mode == MODE_PORT && $stable(main_mode)
		|=> port_data_ff == $past(main_s2_ff) && !main_osc_enable)
		else $error("main pins not in port mode");
	main_halt_a: assert property (main_halt_ff |=> !main_div_tick_ff ##1 !main_div_tick_ff)
		else $error("main oscillator ticks while halted");
	mode_once_a: assert property (mode_locked_ff && wr_go && awaddr_ff == OFS_MODE
		|=> $stable(mode_ff))
		else $error("mode register rewritten after lock");
	sub_mode_a: assert property (sub_tick_ff |-> $past(sub_mode == MODE_OSC
		|| sub_mode == MODE_EXT))
		else $error("sub tick in port mode");
	main_status_a: assert property ($fell(main_stat) |-> !main_sel_ff && $past(fast_tick_ff))
		else $error("main status fell without fast edge");
	cpu_status_a: assert property ($rose(cpu_stat) |-> cpu_sel_ff && $past(sub_path_tick))
		else $error("cpu status rose without sub path edge");

	main_back_c: cover property ($fell(main_stat));
	cpu_sub_c:   cover property ($rose(cpu_stat) && !ls_stat);
	cpu_low_c:   cover property ($rose(cpu_stat) && ls_stat);
	mode_ref_c:  cover property (mode_locked_ff && wr_go && awaddr_ff == OFS_MODE);

endmodule : ccss_top
`default_nettype wire

// file: ccss_top_tb.sv
`default_nettype none
module ccss_top_tb import ccss_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb, option_freq_sel;
	logic [1:0]  s_axi_bresp, s_axi_rresp, main_crystal_osc, main_pins_port_data, sub_osc_drive, rsp;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, fast_osc_range_option, sub_crystal_osc, main_osc_enable, xon, ph;
	logic        main_osc_gain_high, sub_osc_enable, sub_low_power_ctrl, fast_internal_clk_en;
	logic        main_system_clk_en, cpu_peripheral_clock;
	int          n_fail, tests_run;

	ccss_top #(.LOW_SPEED_DIV(10)) ccss_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .option_freq_sel, .fast_osc_range_option,
		.main_crystal_osc, .sub_crystal_osc, .main_pins_port_data, .main_osc_enable,
		.main_osc_gain_high, .sub_osc_enable, .sub_osc_drive, .sub_low_power_ctrl,
		.fast_internal_clk_en, .main_system_clk_en, .cpu_peripheral_clock);

	// Clock
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// Main crystal pin 50 MHz, sub crystal pin 25 MHz once enabled
	always @(posedge aclk) begin
		ph <= ~ph;
		if (xon && ph) main_crystal_osc[0] <= ~main_crystal_osc[0];
		if (xon && ph && main_crystal_osc[0]) sub_crystal_osc <= ~sub_crystal_osc;
	end

	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk

	// AXI4-Lite write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && s_axi_awready) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	// AXI4-Lite read
	task automatic rdx(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rdx

	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		rdx(a);
		chk(nm, rd, e);
	endtask : rc

	// Poll a status bit until it reaches the wanted level
	task automatic pl(input string nm, input int b, input logic v);
		for (int k = 0; k < 300; k++) begin
			rdx(OFS_SEL);
			if (rd[b] === v) break;
		end
		chk(nm, 32'(rd[b]), 32'(v));
	endtask : pl

	// Count clock-enable pulses over a window, allow one of phase slack
	// Source 0 is the CPU clock, 1 the fast clock, 2 the main system clock
	task automatic nr(input string nm, input logic [1:0] w, input int cyc, input int e);
		int   n;
		logic s;
		n = 0;
		repeat (cyc) begin
			@(posedge aclk);
			#1;
			s = w[1] ? main_system_clk_en : w[0] ? fast_internal_clk_en : cpu_peripheral_clock;
			if (s === 1'b1) n++;
		end
		chk(nm, 32'(n >= e - 1 && n <= e + 1), 32'h1);
	endtask : nr

	initial begin
		#400000;
		n_fail++;
		finish_test();
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, xon, ph, sub_crystal_osc} = '0;
		s_axi_wstrb = 4'hF;
		option_freq_sel = 4'h1;
		fast_osc_range_option = 1'b1;
		main_crystal_osc = 2'h2;
		n_fail = 0;
		tests_run = 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		// Strap capture needs three edges after release
		repeat (4) @(posedge aclk);
		// Reset state and fast clock at 4 MHz
		rc("option", OFS_OPT, 32'h11);
		rc("run", OFS_RUN, 32'hC0);
		rc("select", OFS_SEL, 32'h00);
		rc("stab_sel", OFS_STS, 32'h07);
		nr("cpu_fast", 2'h0, 2000, 40);
		chk("port_data", 32'(main_pins_port_data), 32'h2);
		wr(OFS_FDIV, 8'h01);
		nr("cpu_fast_div", 2'h0, 2000, 20);
		// Unmapped place
		wr(8'h28, 8'h5A);
		chk("unmapped_wr", 32'(rsp), 32'(RESP_SLVERR));
		rc("unmapped_rd", 8'h28, 32'h0);
		chk("unmapped_rsp", 32'(rsp), 32'(RESP_SLVERR));
		// Mode register taken once only
		wr(OFS_MODE, 8'h5D);
		wr(OFS_MODE, 8'h00);
		rc("mode", OFS_MODE, 32'h5D);
		chk("gain", 32'(main_osc_gain_high), 32'h1);
		chk("sub_drive", 32'(sub_osc_drive), 32'h3);
		chk("port_off", 32'(main_pins_port_data), 32'h0);
		wr(OFS_SUBM, 8'h80);
		chk("sub_lowpwr", 32'(sub_low_power_ctrl), 32'h1);
		// Start main and sub oscillators, main divided to 25 MHz
		wr(OFS_STS, 8'h00);
		wr(OFS_MAIN_CLOCK_DIVIDER, 8'h01);
		xon <= 1'b1;
		wr(OFS_RUN, 8'h00);
		chk("main_en", 32'(main_osc_enable), 32'h1);
		chk("sub_en", 32'(sub_osc_enable), 32'h1);
		rdx(OFS_STC);
		for (int k = 0; k < 1000 && rd[0] !== 1'b1; k++) rdx(OFS_STC);
		chk("stab_done", 32'(rd[0]), 32'h1);
		wr(OFS_SEL, 8'h10);
		pl("main_stat_on", SEL_MAIN_STAT, 1'b1);
		nr("cpu_main", 2'h0, 400, 50);
		nr("main_sys", 2'h2, 400, 50);
		wr(OFS_SEL, 8'h00);
		pl("main_stat_off", SEL_MAIN_STAT, 1'b0);
		// Low-speed source, then back onto the sub crystal
		wr(OFS_LSP, 8'h01);
		wr(OFS_SEL, 8'h40);
		pl("cpu_stat", SEL_CPU_STAT, 1'b1);
		nr("cpu_low", 2'h0, 400, 40);
		wr(OFS_LSP, 8'h00);
		repeat (40) @(posedge aclk);
		nr("cpu_sub", 2'h0, 400, 50);
		// Halt and restart the fast oscillator, wait 105 us, then return onto it
		wr(OFS_RUN, 8'h01);
		nr("fast_halted", 2'h1, 400, 0);
		wr(OFS_RUN, 8'h00);
		nr("fast_restart", 2'h1, 400, 4);
		repeat (21000) @(posedge aclk);
		wr(OFS_SEL, 8'h00);
		pl("cpu_back", SEL_CPU_STAT, 1'b0);
		wr(OFS_RUN, 8'h80);
		chk("main_stop", 32'(main_osc_enable), 32'h0);
		// Second reset, then external main clock input mode
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		rc("run_again", OFS_RUN, 32'hC0);
		wr(OFS_MODE, 8'hC0);
		rc("mode_again", OFS_MODE, 32'hC0);
		wr(OFS_RUN, 8'h00);
		chk("ext_osc_off", 32'(main_osc_enable), 32'h0);
		wr(OFS_SEL, 8'h10);
		pl("ext_main", SEL_MAIN_STAT, 1'b1);
		nr("ext_rate", 2'h2, 400, 100);
		finish_test();
	end
endmodule : ccss_top_tb
`default_nettype wire
